// ==== rtl/cmc_master_control.sv ====
// Master control and general status of a one-channel CAN controller.
// Assumes an AHB-Lite master on sys_clk, a protocol engine on the same
// clock supplying error counts and frame events, and can_rx from a pin.
`timescale 1ns/100ps
module cmc_master_control (
  input  wire logic                        sys_clk,
  input  wire logic                        rst_n,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [cmc_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  // Standby and pin
  input  wire logic                        hw_standby,
  input  wire logic                        sw_standby,
  input  wire logic                        can_rx,
  // Protocol engine side
  input  wire logic [cmc_pkg::ERR_W-1:0]   tx_err_count,
  input  wire logic [cmc_pkg::ERR_W-1:0]   rx_err_count,
  input  wire logic                        tx_sof_pulse,
  input  wire logic                        intermission3_pulse,
  input  wire logic                        busoff_recover_pulse,
  output logic                             mode_reset,
  output logic                             mode_config,
  output logic                             mode_sleep,
  output logic                             mode_halt,
  output logic                             bus_on,
  output logic                             transmit_order_select
);

  cmc_pkg::cmc_mode_e              mode_reg;
  cmc_pkg::cmc_mode_e              mode_next;
  logic [cmc_pkg::CNT_W-1:0]       cnt_reg;
  logic                            auto_wake_enable;
  logic                            sleep_request;
  logic                            halt_request;
  logic                            reset_request;
  logic                            reset_state_flag;
  logic                            transmission_idle_flag;
  logic                            error_warning_flag;
  logic                            bus_off_flag;
  logic                            rx_sync;
  logic                            bus_activity;
  logic                            wake_event;
  logic                            wr_pend_reg;
  logic [cmc_pkg::ADDR_W-1:0]      addr_reg;
  logic                            addr_phase;
  logic                            mc_write;
  logic [7:0]                      wdata;
  logic [7:0]                      mc_view;
  logic [7:0]                      gs_view;

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  cmc_sync #(
    .RESET_VAL (cmc_pkg::CAN_RECESSIVE)
  ) u_rx_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .async_in  (can_rx),
    .sync_out  (rx_sync)
  );

  // Any dominant level counts as bus activity
  assign bus_activity = (rx_sync != cmc_pkg::CAN_RECESSIVE);
  assign wake_event   = (mode_reg == cmc_pkg::CMC_SLEEP) &&
                        auto_wake_enable && bus_activity;

  // ==========================================================
  // Bus slave
  // ==========================================================
  assign addr_phase = hsel && hready && (htrans == cmc_pkg::HTRANS_NONSEQ);
  assign wdata      = hwdata[7:0];
  assign mc_write   = wr_pend_reg &&
                      (addr_reg == cmc_pkg::OFS_MASTER_CONTROL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= cmc_pkg::OFS_MASTER_CONTROL;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_reg <= haddr;
      end
    end
  end

  // Zero wait states; the slave never stalls and always answers OKAY
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= cmc_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= cmc_pkg::HRESP_OKAY;
    end
  end

  always_comb begin
    mc_view = 8'h00;
    mc_view[cmc_pkg::MC_AUTO_WAKE] = auto_wake_enable;
    mc_view[cmc_pkg::MC_SLEEP_REQ] = sleep_request;
    mc_view[cmc_pkg::MC_TX_ORDER]  = transmit_order_select;
    mc_view[cmc_pkg::MC_HALT_REQ]  = halt_request;
    mc_view[cmc_pkg::MC_RESET_REQ] = reset_request;
  end

  always_comb begin
    gs_view = 8'h00;
    gs_view[cmc_pkg::GS_RESET_STATE] = reset_state_flag;
    gs_view[cmc_pkg::GS_TX_IDLE]     = transmission_idle_flag;
    gs_view[cmc_pkg::GS_WARNING]     = error_warning_flag;
    gs_view[cmc_pkg::GS_BUS_OFF]     = bus_off_flag;
  end

  // Read data is caught at the address phase; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= cmc_pkg::RDATA_ZERO;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr)
        cmc_pkg::OFS_MASTER_CONTROL: hrdata <= {24'h00_0000, mc_view};
        cmc_pkg::OFS_GENERAL_STATUS: hrdata <= {24'h00_0000, gs_view};
        default:                     hrdata <= cmc_pkg::RDATA_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Master control register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_wake_enable      <= cmc_pkg::RST_AUTO_WAKE;
      transmit_order_select <= cmc_pkg::RST_TX_ORDER;
      halt_request          <= cmc_pkg::RST_HALT_REQ;
    end else if (mc_write) begin
      auto_wake_enable      <= wdata[cmc_pkg::MC_AUTO_WAKE];
      transmit_order_select <= wdata[cmc_pkg::MC_TX_ORDER];
      halt_request          <= wdata[cmc_pkg::MC_HALT_REQ];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_request <= cmc_pkg::RST_SLEEP_REQ;
    end else if (mc_write) begin
      sleep_request <= wdata[cmc_pkg::MC_SLEEP_REQ];
    end else if (wake_event) begin
      sleep_request <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_request <= cmc_pkg::RST_RESET_REQ;
    end else if (hw_standby || sw_standby ||
                 (mc_write && wdata[cmc_pkg::MC_RESET_REQ])) begin
      reset_request <= 1'b1;
    end else if (mc_write && reset_state_flag) begin
      // zero honoured only in reset state
      reset_request <= 1'b0;
    end
  end

  // ==========================================================
  // Mode sequencer
  // ==========================================================
  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      cmc_pkg::CMC_RESET: begin
        if (cnt_reg == cmc_pkg::RESET_LAST) begin
          mode_next = cmc_pkg::CMC_CONFIG;
        end
      end
      cmc_pkg::CMC_CONFIG: begin
        if (!reset_request) begin
          mode_next = cmc_pkg::CMC_JOIN;
        end
      end
      cmc_pkg::CMC_JOIN: begin
        if (reset_request) begin
          mode_next = cmc_pkg::CMC_RESET;
        end else if (cnt_reg == cmc_pkg::JOIN_LAST) begin
          mode_next = cmc_pkg::CMC_NORMAL;
        end
      end
      cmc_pkg::CMC_NORMAL: begin
        if (reset_request) begin
          mode_next = cmc_pkg::CMC_RESET;
        end else if (sleep_request) begin
          mode_next = cmc_pkg::CMC_SLEEP;
        end else if (halt_request) begin
          mode_next = cmc_pkg::CMC_HALT;
        end
      end
      cmc_pkg::CMC_HALT: begin
        if (reset_request) begin
          mode_next = cmc_pkg::CMC_RESET;
        end else if (sleep_request) begin
          mode_next = cmc_pkg::CMC_SLEEP;
        end else if (!halt_request) begin
          mode_next = cmc_pkg::CMC_NORMAL;
        end
      end
      cmc_pkg::CMC_SLEEP: begin
        if (reset_request) begin
          mode_next = cmc_pkg::CMC_RESET;
        end else if (!sleep_request) begin
          mode_next = cmc_pkg::CMC_JOIN;
        end
      end
      default: begin
        mode_next = cmc_pkg::CMC_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= cmc_pkg::CMC_RESET;
      cnt_reg  <= cmc_pkg::CNT_ZERO;
    end else begin
      mode_reg <= mode_next;
      if (mode_next != mode_reg) begin
        cnt_reg <= cmc_pkg::CNT_ZERO;
      end else begin
        cnt_reg <= cnt_reg + cmc_pkg::CNT_ONE;
      end
    end
  end

  // Mode outputs follow the next state so they stand with mode_reg
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reset  <= 1'b1;
      mode_config <= 1'b0;
      mode_sleep  <= 1'b0;
      mode_halt   <= 1'b0;
      bus_on      <= 1'b0;
    end else begin
      mode_reset  <= (mode_next == cmc_pkg::CMC_RESET);
      mode_config <= (mode_next == cmc_pkg::CMC_CONFIG);
      mode_sleep  <= (mode_next == cmc_pkg::CMC_SLEEP);
      mode_halt   <= (mode_next == cmc_pkg::CMC_HALT);
      bus_on      <= (mode_next == cmc_pkg::CMC_NORMAL) ||
                     (mode_next == cmc_pkg::CMC_HALT);
    end
  end

  // ==========================================================
  // General status register
  // ==========================================================
  // no bus write path here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_state_flag <= cmc_pkg::RST_RESET_STATE;
    end else if (mode_next == cmc_pkg::CMC_CONFIG ||
                 mode_next == cmc_pkg::CMC_SLEEP) begin
      reset_state_flag <= 1'b1;
    end else if (mode_next == cmc_pkg::CMC_NORMAL) begin
      reset_state_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transmission_idle_flag <= cmc_pkg::RST_TX_IDLE;
    end else if (intermission3_pulse || !bus_on) begin
      // set wins over start of frame
      transmission_idle_flag <= 1'b1;
    end else if (tx_sof_pulse) begin
      transmission_idle_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_warning_flag <= cmc_pkg::RST_WARNING;
    end else begin
      error_warning_flag <=
        ((tx_err_count >= cmc_pkg::WARN_LIMIT) ||
         (rx_err_count >= cmc_pkg::WARN_LIMIT)) &&
        (tx_err_count < cmc_pkg::BUSOFF_LIMIT);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_off_flag <= cmc_pkg::RST_BUS_OFF;
    end else if (tx_err_count >= cmc_pkg::BUSOFF_LIMIT) begin
      bus_off_flag <= 1'b1;
    end else if (busoff_recover_pulse) begin
      bus_off_flag <= 1'b0;
    end
  end

  // Transfer size is fixed at one word; hsize is not decoded
  logic unused_hsize;
  assign unused_hsize = ^hsize;

endmodule : cmc_master_control

// ==== rtl/cmc_pkg.sv ====
// Constants of the CAN master control and status block.
// Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
package cmc_pkg;

  // ==========================================================
  // Clock and timing
  // ==========================================================
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS  = 1_000_000_000 / SYS_CLK_HZ;
  // Least time spent in internal reset before configuration mode
  localparam int unsigned RESET_TIME_NS  = 200;
  localparam int unsigned RESET_CYC      =
    (RESET_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // Least time between leaving reset or sleep and normal operation
  localparam int unsigned JOIN_TIME_NS   = 550;
  localparam int unsigned JOIN_CYC       =
    (JOIN_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned CNT_W          = 4;
  localparam logic [CNT_W-1:0] RESET_LAST = CNT_W'(RESET_CYC - 1);
  localparam logic [CNT_W-1:0] JOIN_LAST  = CNT_W'(JOIN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE    = 4'h1;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam int unsigned ADDR_W           = 8;
  localparam logic [ADDR_W-1:0] OFS_MASTER_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GENERAL_STATUS = 8'h04;

  // master_control fields
  localparam int unsigned MC_AUTO_WAKE   = 7;
  localparam int unsigned MC_SLEEP_REQ   = 5;
  localparam int unsigned MC_TX_ORDER    = 2;
  localparam int unsigned MC_HALT_REQ    = 1;
  localparam int unsigned MC_RESET_REQ   = 0;

  // general_status fields
  localparam int unsigned GS_RESET_STATE = 3;
  localparam int unsigned GS_TX_IDLE     = 2;
  localparam int unsigned GS_WARNING     = 1;
  localparam int unsigned GS_BUS_OFF     = 0;

  // Reset values
  localparam logic RST_AUTO_WAKE   = 1'b0;
  localparam logic RST_SLEEP_REQ   = 1'b0;
  localparam logic RST_TX_ORDER    = 1'b0;
  localparam logic RST_HALT_REQ    = 1'b0;
  localparam logic RST_RESET_REQ   = 1'b1;
  localparam logic RST_RESET_STATE = 1'b1;
  localparam logic RST_TX_IDLE     = 1'b1;
  localparam logic RST_WARNING     = 1'b0;
  localparam logic RST_BUS_OFF     = 1'b0;

  // ==========================================================
  // Error counter limits
  // ==========================================================
  localparam int unsigned ERR_W          = 9;
  localparam logic [ERR_W-1:0] WARN_LIMIT   = 9'h060;
  localparam logic [ERR_W-1:0] BUSOFF_LIMIT = 9'h100;

  // ==========================================================
  // Bus constants
  // ==========================================================
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'b0;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;
  localparam logic        CAN_RECESSIVE = 1'b1;

  // ==========================================================
  // Controller modes, Gray coded along the usual path
  // ==========================================================
  typedef enum logic [2:0] {
    CMC_RESET  = 3'h0,
    CMC_CONFIG = 3'h1,
    CMC_JOIN   = 3'h3,
    CMC_NORMAL = 3'h2,
    CMC_HALT   = 3'h6,
    CMC_SLEEP  = 3'h7
  } cmc_mode_e;

endpackage : cmc_pkg

// ==== rtl/cmc_sync.sv ====
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the consumer reads only sync_out.
`timescale 1ns/100ps
module cmc_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;

  // ==========================================================
  // First stage feeds only the second
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : cmc_sync

// ==== sim/cmc_can_node.sv ====
// CAN bus seen through the transceiver: drives the receive pin only.
// Assumes the bench raises bus_busy for the length of some bus traffic.
`timescale 1ns/100ps
module cmc_can_node (
  input  wire logic sys_clk,
  input  wire logic bus_busy,
  output logic      can_rx
);
  logic [2:0] bit_cnt = 3'h0;

  // ==========================================
  // Bus traffic
  // ==========================================
  // Four dominant cycles, then recessive ones, so a wake must not need more
  always_ff @(posedge sys_clk) begin
    if (bus_busy) begin
      bit_cnt <= bit_cnt + 3'h1;
    end else begin
      bit_cnt <= 3'h0;
    end
  end
  // Transceiver pulls the pin recessive when nobody drives the bus
  assign can_rx = bus_busy ? bit_cnt[2] : cmc_pkg::CAN_RECESSIVE;
endmodule : cmc_can_node

// ==== sim/cmc_master_control_sva.sv ====
// Checker for the CAN master control block, seeing its ports only.
// Assumes a zero-wait AHB-Lite master and counts on sys_clk.
`timescale 1ns/100ps
module cmc_master_control_sva (
  input wire logic                       sys_clk,
  input wire logic                       rst_n,
  input wire logic                       hsel,
  input wire logic [cmc_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic [31:0]                hwdata,
  input wire logic                       hready,
  input wire logic [31:0]                hrdata,
  input wire logic                       can_rx,
  input wire logic [cmc_pkg::ERR_W-1:0]  tx_err_count,
  input wire logic [cmc_pkg::ERR_W-1:0]  rx_err_count,
  input wire logic                       mode_reset,
  input wire logic                       mode_config,
  input wire logic                       mode_sleep,
  input wire logic                       mode_halt,
  input wire logic                       bus_on,
  input wire logic                       transmit_order_select
);
  logic       ap_v;
  logic       ap_wr;
  logic [7:0] ap_a;
  logic       aw;
  logic       rd_ctl;
  logic       rd_st;
  logic       wr_ctl;

  // ==========================================
  // Data phase tracking
  // ==========================================
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_v  <= 1'b0;
      ap_wr <= 1'b0;
      ap_a  <= 8'h00;
    end else if (hready) begin
      ap_v  <= hsel && htrans == cmc_pkg::HTRANS_NONSEQ;
      ap_wr <= hwrite;
      ap_a  <= haddr;
    end
  end
  assign rd_ctl = ap_v && !ap_wr && ap_a == cmc_pkg::OFS_MASTER_CONTROL;
  assign rd_st  = ap_v && !ap_wr && ap_a == cmc_pkg::OFS_GENERAL_STATUS;
  assign wr_ctl = ap_v && ap_wr && ap_a == cmc_pkg::OFS_MASTER_CONTROL;
  // Shadow of the auto wake bit, kept from bus writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw <= 1'b0;
    end else if (wr_ctl) begin
      aw <= hwdata[cmc_pkg::MC_AUTO_WAKE];
    end
  end

  // ==========================================
  // Properties
  // ==========================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ctl_reserved: assert property (
    rd_ctl |-> hrdata[31:8] == 24'h0 && !hrdata[6] && hrdata[4:3] == 2'h0)
    else $error("control reserved bits not zero");
  a_st_reserved: assert property (
    rd_st |-> hrdata[31:4] == 28'h0)
    else $error("status reserved bits not zero");
  a_warn_flag: assert property (
    rd_st |-> hrdata[1] == (($past(tx_err_count, 2) >= cmc_pkg::WARN_LIMIT
      || $past(rx_err_count, 2) >= cmc_pkg::WARN_LIMIT)
      && $past(tx_err_count, 2) < cmc_pkg::BUSOFF_LIMIT))
    else $error("warning flag wrong for counts");
  a_order_bit: assert property (
    wr_ctl |=> transmit_order_select == $past(hwdata[2]))
    else $error("order output not following write");
  a_halt_bus: assert property (
    (mode_halt |-> bus_on && !mode_sleep && !mode_config) and
    (wr_ctl && bus_on && hwdata[1] && !hwdata[5] && !hwdata[0]
      |=> ##1 mode_halt))
    else $error("halt entry or overlap wrong");
  a_sleep_excl: assert property (
    (mode_sleep |-> !bus_on && !mode_halt && !mode_reset) and
    (wr_ctl && bus_on && hwdata[5] && !hwdata[0] |=> ##1 mode_sleep))
    else $error("sleep entry or overlap wrong");
  a_reset_excl: assert property (
    (mode_reset |-> !mode_config && !bus_on) and
    (rd_ctl && hrdata[0] |-> !bus_on))
    else $error("bus on while reset requested");
  a_wake_bus: assert property (
    (mode_sleep && aw && !can_rx) [*3] |-> ##[0:6] !mode_sleep)
    else $error("no wake on bus activity");
  a_join_delay: assert property (
    ($fell(mode_config) || $fell(mode_sleep)) && !mode_reset && !mode_sleep
      && !mode_config |-> !bus_on [*8] ##[2:5] bus_on)
    else $error("normal entry timing wrong");
endmodule : cmc_master_control_sva

bind cmc_master_control cmc_master_control_sva i_sva (.sys_clk, .rst_n,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .can_rx,
  .tx_err_count, .rx_err_count, .mode_reset, .mode_config, .mode_sleep,
  .mode_halt, .bus_on, .transmit_order_select);

// ==== sim/testbench.sv ====
// Self-checking bench for the CAN master control block.
// Assumes the checker is bound in and the node model drives can_rx.
`timescale 1ns/100ps
module testbench;
  logic        sys_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic        hw_standby, sw_standby, can_rx, bus_busy;
  logic [8:0]  tx_err_count, rx_err_count;
  logic        tx_sof_pulse, intermission3_pulse, busoff_recover_pulse;
  logic        mode_reset, mode_config, mode_sleep, mode_halt, bus_on;
  logic        transmit_order_select;
  int          err_count, samples_checked;
  localparam logic [7:0] MC = cmc_pkg::OFS_MASTER_CONTROL;
  localparam logic [7:0] GS = cmc_pkg::OFS_GENERAL_STATUS;
  logic [8:0]  tv [5] = '{9'h05f, 9'h060, 9'h000, 9'h05f, 9'h100};
  logic [8:0]  rv [5] = '{9'h05f, 9'h000, 9'h060, 9'h05f, 9'h000};
  logic [31:0] ev [5] = '{32'h0, 32'h2, 32'h2, 32'h0, 32'h1};

  cmc_master_control i_dut (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .hw_standby, .sw_standby, .can_rx, .tx_err_count,
    .rx_err_count, .tx_sof_pulse, .intermission3_pulse,
    .busoff_recover_pulse, .mode_reset, .mode_config, .mode_sleep,
    .mode_halt, .bus_on, .transmit_order_select);
  cmc_can_node i_node (.sys_clk, .bus_busy, .can_rx);

  // ==========================================
  // Bus tasks
  // ==========================================
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick
  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= cmc_pkg::HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input string n);
    xfer(1'b0, a, 32'h0);
    chk(n, r & m, e);
  endtask : rd
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  // ==========================================
  // Clock, watchdog, tests
  // ==========================================
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Tests take well under a thousand cycles
  initial begin
    tick(5000);
    err_count++;
    stop_test();
  end
  initial begin
    {rst_n, hsel, hwrite, hw_standby, sw_standby, bus_busy} = '0;
    {tx_sof_pulse, intermission3_pulse, busoff_recover_pulse} = '0;
    {haddr, htrans, hwdata, tx_err_count, rx_err_count} = '0;
    hsize = 3'h2;
    tick(20);
    rst_n <= 1'b1;
    tick(10);
    rd(MC, 32'hff, 32'h01, "ctl_reset");
    rd(GS, 32'hff, 32'h0c, "st_reset");
    chk("pin_window", {31'h0, mode_config}, 32'h1);
    // Reserved bits are only ever written as zero
    xfer(1'b1, MC, 32'h05);
    rd(MC, 32'hff, 32'h05, "ctl_reserved");
    chk("order_one", {31'h0, transmit_order_select}, 32'h1);
    xfer(1'b1, MC, 32'h01);
    tick(1);
    chk("order_zero", {31'h0, transmit_order_select}, 32'h0);
    // Every flag written to its inverse, reserved bits as zero
    xfer(1'b1, GS, 32'h03);
    rd(GS, 32'hff, 32'h0c, "st_readonly");
    xfer(1'b1, MC, 32'h00);
    rd(MC, 32'hff, 32'h00, "ctl_req_clear");
    rd(GS, 32'hff, 32'h0c, "st_lag");
    tick(15);
    rd(GS, 32'hff, 32'h04, "st_normal");
    xfer(1'b1, MC, 32'h02);
    tick(3);
    chk("halt_on", {31'h0, mode_halt}, 32'h1);
    xfer(1'b1, MC, 32'h00);
    tick(3);
    chk("halt_off", {30'h0, mode_halt, bus_on}, 32'h1);
    tx_sof_pulse <= 1'b1;
    tick(1);
    tx_sof_pulse <= 1'b0;
    rd(GS, 32'h04, 32'h00, "tx_busy");
    intermission3_pulse <= 1'b1;
    tick(1);
    intermission3_pulse <= 1'b0;
    rd(GS, 32'h04, 32'h04, "tx_idle");
    for (int i = 0; i < 5; i++) begin
      tx_err_count <= tv[i];
      rx_err_count <= rv[i];
      tick(3);
      rd(GS, 32'h03, ev[i], "warn_busoff");
    end
    tx_err_count <= 9'h000;
    tick(3);
    rd(GS, 32'h03, 32'h01, "busoff_hold");
    busoff_recover_pulse <= 1'b1;
    tick(1);
    busoff_recover_pulse <= 1'b0;
    rd(GS, 32'h03, 32'h00, "busoff_clear");
    xfer(1'b1, MC, 32'h20);
    tick(3);
    rd(GS, 32'h08, 32'h08, "sleep_flag");
    xfer(1'b1, MC, 32'h00);
    tick(15);
    rd(GS, 32'h08, 32'h00, "sleep_exit");
    xfer(1'b1, MC, 32'ha0);
    tick(3);
    bus_busy <= 1'b1;
    tick(6);
    bus_busy <= 1'b0;
    chk("wake", {31'h0, mode_sleep}, 32'h0);
    rd(MC, 32'hff, 32'h80, "wake_ctl");
    tick(15);
    for (int i = 0; i < 2; i++) begin
      hw_standby <= (i == 0);
      sw_standby <= (i == 1);
      tick(2);
      hw_standby <= 1'b0;
      sw_standby <= 1'b0;
      xfer(1'b1, MC, 32'h00);
      tick(10);
      rd(MC, 32'h01, 32'h01, "standby_req");
      chk("standby_cfg", {31'h0, mode_config}, 32'h1);
      xfer(1'b1, MC, 32'h00);
      tick(15);
    end
    stop_test();
  end
endmodule : testbench
